//--- hw/oring_ctrl_regs.vh
// Purpose: Offsets, fields and reset values of the rail OR-ing controller
// Assumes: 8-bit register data, 4-bit word index on the register port
// Notes:   Definitions only; included by the controller
`ifndef ORING_CTRL_REGS_VH
`define ORING_CTRL_REGS_VH

// ==========================================================
// Register offsets (word index)
`define REG_CONTROL      4'h0
`define REG_STATUS       4'h1
`define REG_RAIL_LOW     4'h2
`define REG_RAIL_HIGH    4'h3
`define REG_A_ON_LEVEL   4'h4
`define REG_A_OFF_LEVEL  4'h5
`define REG_B_ON_LEVEL   4'h6
`define REG_B_OFF_LEVEL  4'h7

// ==========================================================
// Control register fields
`define CTL_RUN          0
`define CTL_ALLOW_A      1
`define CTL_ALLOW_B      2
`define CTL_USED_MASK    8'h07

// ==========================================================
// Status register fields
`define STS_STATE_LO     0
`define STS_STATE_HI     1
`define STS_GATE_A       2
`define STS_GATE_B       3
`define STS_LOAD_EN      4
`define STS_RAIL_A_OK    5
`define STS_RAIL_B_OK    6
`define STS_LOAD_ON      7

// ==========================================================
// Reset values
`define RST_CONTROL      8'h07
`define RST_RAIL_LOW     8'hA0
`define RST_RAIL_HIGH    8'hC0
`define RST_ON_LEVEL     8'h40
`define RST_OFF_LEVEL    8'h20

// ==========================================================
// Sequencer states
`define ST_WAIT_RAIL     2'h0
`define ST_ENABLE_LOAD   2'h1
`define ST_WAIT_LOAD     2'h2
`define ST_RUN           2'h3

`endif

//--- hw/pin_sync.v
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to CLOCK
// Notes:   Output moves only when stages two and three agree
`default_nettype none

module pin_sync #(
  parameter WIDTH = 9
) (
  input  wire             CLOCK,
  input  wire             RST,
  input  wire [WIDTH-1:0] PIN,
  output reg  [WIDTH-1:0] LEVEL
);

  // ==========================================================
  // Storage
  reg [WIDTH-1:0] meta;   // First stage, read only by stage two
  reg [WIDTH-1:0] stage2; // Second stage
  reg [WIDTH-1:0] stage3; // Third stage

  // ==========================================================
  // Shift chain
  // Metastability guard, then a one-cycle agreement check
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      meta   <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
    end else begin
      meta   <= PIN;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // ==========================================================
  // Agreement filter
  // A one-cycle glitch never reaches the output
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      LEVEL <= {WIDTH{1'b0}};
    end else begin
      // Agree high sets, agree low clears, disagreement holds
      LEVEL <= (stage2 & stage3) | (LEVEL & (stage2 | stage3));
    end
  end

endmodule

`default_nettype wire

//--- hw/oring_ctrl.v
// Purpose: Two-limb supply OR-ing sequencer with pass-gate control
// Assumes: Comparator and load-good pins are asynchronous to CLOCK
// Notes:   Threshold levels are outputs that set external comparators
`default_nettype none

`include "oring_ctrl_regs.vh"

// Function
// - Both pass gates off after reset
// - Wait until one input rail valid
// - Valid rail seen: assert load enable
// - Wait load good before gate decisions
// - Close gate only above turn-on level
// - Both limbs high: both gates on
// - Below turn-off level: gate off immediately
// - Reclose gate when current rises again
// - Both limbs decided in parallel, continuously
// - Two comparators per limb give hysteresis
// - Rail window lower and upper settable
module oring_ctrl (
  input  wire       CLOCK,
  input  wire       RST,
  // Register port
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // Rail window comparators, one pair per rail
  input  wire       INPUT_RAIL_A_ABOVE_LOW,
  input  wire       INPUT_RAIL_A_ABOVE_HIGH,
  input  wire       INPUT_RAIL_B_ABOVE_LOW,
  input  wire       INPUT_RAIL_B_ABOVE_HIGH,
  // Limb current comparators, turn-on and turn-off
  input  wire       LIMB_A_CURRENT_SENSE_ABOVE_ON,
  input  wire       LIMB_A_CURRENT_SENSE_BELOW_OFF,
  input  wire       LIMB_B_CURRENT_SENSE_ABOVE_ON,
  input  wire       LIMB_B_CURRENT_SENSE_BELOW_OFF,
  // Load started indication
  input  wire       LOAD_GOOD,
  // Outputs toward load and pass gates
  output reg        LOAD_ENABLE,
  output reg        GATE_A,
  output reg        GATE_B,
  // Comparator level settings
  output reg  [7:0] RAIL_LOW_LEVEL,
  output reg  [7:0] RAIL_HIGH_LEVEL,
  output reg  [7:0] LIMB_A_ON_LEVEL,
  output reg  [7:0] LIMB_A_OFF_LEVEL,
  output reg  [7:0] LIMB_B_ON_LEVEL,
  output reg  [7:0] LIMB_B_OFF_LEVEL
);

  // ==========================================================
  // Functions

  // Rail inside its window: above low, not above high
  function rail_valid;
    input above_low;
    input above_high;
    begin
      rail_valid = above_low & ~above_high;
    end
  endfunction

  // Next gate state for one limb with hysteresis
  // Turn-off wins over turn-on so a falling limb never stays closed
  function gate_next;
    input current_gate;
    input allow;
    input above_on;
    input below_off;
    begin
      if (!allow) begin
        gate_next = 1'b0;          // Software forbids this limb
      end else if (below_off) begin
        gate_next = 1'b0;
      end else if (above_on) begin
        gate_next = 1'b1;
      end else begin
        gate_next = current_gate;  // Between levels: hold
      end
    end
  endfunction

  // ==========================================================
  // Pin synchronisation
  wire [8:0] pin_raw;   // Raw pin vector
  wire [8:0] pin_level; // Filtered, clock-domain levels

  assign pin_raw = {LOAD_GOOD,
                    LIMB_B_CURRENT_SENSE_BELOW_OFF,
                    LIMB_B_CURRENT_SENSE_ABOVE_ON,
                    LIMB_A_CURRENT_SENSE_BELOW_OFF,
                    LIMB_A_CURRENT_SENSE_ABOVE_ON,
                    INPUT_RAIL_B_ABOVE_HIGH,
                    INPUT_RAIL_B_ABOVE_LOW,
                    INPUT_RAIL_A_ABOVE_HIGH,
                    INPUT_RAIL_A_ABOVE_LOW};

  // Three sync flops plus a filter flop per pin; level moves once stages two and three agree
  pin_sync #(
    .WIDTH (9)
  ) u_pin_sync (
    .CLOCK (CLOCK),
    .RST   (RST),
    .PIN   (pin_raw),
    .LEVEL (pin_level)
  );

  // Named views of the filtered levels
  wire rail_a_low_ok;  // Rail A above lower level
  wire rail_a_high;    // Rail A above upper level
  wire rail_b_low_ok;  // Rail B above lower level
  wire rail_b_high;    // Rail B above upper level
  wire a_above_on;     // Limb A above turn-on level
  wire a_below_off;    // Limb A below turn-off level
  wire b_above_on;     // Limb B above turn-on level
  wire b_below_off;    // Limb B below turn-off level
  wire load_on;        // Load reports it has started

  assign rail_a_low_ok = pin_level[0];
  assign rail_a_high   = pin_level[1];
  assign rail_b_low_ok = pin_level[2];
  assign rail_b_high   = pin_level[3];
  assign a_above_on    = pin_level[4];
  assign a_below_off   = pin_level[5];
  assign b_above_on    = pin_level[6];
  assign b_below_off   = pin_level[7];
  assign load_on       = pin_level[8];

  // ==========================================================
  // Rail validity
  wire rail_a_ok;  // Rail A inside window
  wire rail_b_ok;  // Rail B inside window
  wire any_rail;   // At least one rail usable

  assign rail_a_ok = rail_valid(rail_a_low_ok, rail_a_high);
  assign rail_b_ok = rail_valid(rail_b_low_ok, rail_b_high);
  assign any_rail  = rail_a_ok | rail_b_ok;

  // ==========================================================
  // Register storage
  reg [7:0] control; // Run and per-limb allow bits

  wire run;     // Sequencer permitted to advance
  wire allow_a; // Limb A may be closed
  wire allow_b; // Limb B may be closed

  assign run     = control[`CTL_RUN];
  assign allow_a = control[`CTL_ALLOW_A];
  assign allow_b = control[`CTL_ALLOW_B];

  // Write decode
  // Levels change live; external comparators settle on their own
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      control          <= `RST_CONTROL;
      RAIL_LOW_LEVEL   <= `RST_RAIL_LOW;
      RAIL_HIGH_LEVEL  <= `RST_RAIL_HIGH;
      LIMB_A_ON_LEVEL  <= `RST_ON_LEVEL;
      LIMB_A_OFF_LEVEL <= `RST_OFF_LEVEL;
      LIMB_B_ON_LEVEL  <= `RST_ON_LEVEL;
      LIMB_B_OFF_LEVEL <= `RST_OFF_LEVEL;
    end else if (WR) begin
      case (ADDR)
        `REG_CONTROL: begin
          control <= WDATA & `CTL_USED_MASK;
        end
        `REG_RAIL_LOW: begin
          RAIL_LOW_LEVEL <= WDATA;
        end
        `REG_RAIL_HIGH: begin
          RAIL_HIGH_LEVEL <= WDATA;
        end
        `REG_A_ON_LEVEL: begin
          LIMB_A_ON_LEVEL <= WDATA;
        end
        `REG_A_OFF_LEVEL: begin
          LIMB_A_OFF_LEVEL <= WDATA;
        end
        `REG_B_ON_LEVEL: begin
          LIMB_B_ON_LEVEL <= WDATA;
        end
        `REG_B_OFF_LEVEL: begin
          LIMB_B_OFF_LEVEL <= WDATA;
        end
        default: begin
          // Status and unmapped: write ignored
        end
      endcase
    end
  end

  // ==========================================================
  // Sequencer
  localparam [1:0] WAIT_RAIL   = `ST_WAIT_RAIL;
  localparam [1:0] ENABLE_LOAD = `ST_ENABLE_LOAD;
  localparam [1:0] WAIT_LOAD   = `ST_WAIT_LOAD;
  localparam [1:0] RUN         = `ST_RUN;

  reg [1:0] state;       // Current step
  reg [1:0] next_state;  // Step for next cycle

  // Step selection
  // Losing every rail or the run bit drops back to the start
  always @* begin
    next_state = state;
    if (!run || !any_rail) begin
      next_state = WAIT_RAIL;
    end else begin
      case (state)
        WAIT_RAIL: begin
          next_state = ENABLE_LOAD;  // a rail is valid
        end
        ENABLE_LOAD: begin
          next_state = WAIT_LOAD;
        end
        WAIT_LOAD: begin
          if (load_on) begin
            next_state = RUN;
          end
        end
        RUN: begin
          next_state = RUN;          // stays here until run is cleared or every rail is lost
        end
        default: begin
          next_state = WAIT_RAIL;
        end
      endcase
    end
  end

  // State register
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= WAIT_RAIL;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Output decisions
  reg next_load_enable; // Load enable for next cycle
  reg next_gate_a;      // Limb A gate for next cycle
  reg next_gate_b;      // Limb B gate for next cycle

  // Gates only act in RUN; body diodes carry the load before
  always @* begin
    next_load_enable = 1'b0;
    next_gate_a      = 1'b0;
    next_gate_b      = 1'b0;
    case (next_state)
      WAIT_RAIL: begin
        next_load_enable = 1'b0;
      end
      ENABLE_LOAD: begin
        next_load_enable = 1'b1;
      end
      WAIT_LOAD: begin
        next_load_enable = 1'b1;  // gates stay open
      end
      RUN: begin
        next_load_enable = 1'b1;
        // Both limbs evaluated side by side every cycle
        next_gate_a = gate_next(GATE_A, allow_a,
                                a_above_on, a_below_off);
        next_gate_b = gate_next(GATE_B, allow_b,
                                b_above_on, b_below_off);
      end
      default: begin
        next_load_enable = 1'b0;
      end
    endcase
  end

  // Registered drive; turn-off lands one edge after the level
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      LOAD_ENABLE <= 1'b0;
      GATE_A      <= 1'b0;
      GATE_B      <= 1'b0;
    end else begin
      LOAD_ENABLE <= next_load_enable;
      GATE_A      <= next_gate_a;
      GATE_B      <= next_gate_b;
    end
  end

  // ==========================================================
  // Status view
  wire [7:0] status; // Live controller state

  assign status = {load_on,
                   rail_b_ok,
                   rail_a_ok,
                   LOAD_ENABLE,
                   GATE_B,
                   GATE_A,
                   state};

  // ==========================================================
  // Read path
  // Data appear the cycle after the strobe; zero otherwise
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `REG_CONTROL: begin
          RDATA <= control;
        end
        `REG_STATUS: begin
          RDATA <= status;
        end
        `REG_RAIL_LOW: begin
          RDATA <= RAIL_LOW_LEVEL;
        end
        `REG_RAIL_HIGH: begin
          RDATA <= RAIL_HIGH_LEVEL;
        end
        `REG_A_ON_LEVEL: begin
          RDATA <= LIMB_A_ON_LEVEL;
        end
        `REG_A_OFF_LEVEL: begin
          RDATA <= LIMB_A_OFF_LEVEL;
        end
        `REG_B_ON_LEVEL: begin
          RDATA <= LIMB_B_ON_LEVEL;
        end
        `REG_B_OFF_LEVEL: begin
          RDATA <= LIMB_B_OFF_LEVEL;
        end
        default: begin
          RDATA <= 8'h00;  // Unmapped reads zero
        end
      endcase
    end else begin
      RDATA <= 8'h00;  // Data valid only after a read
    end
  end

endmodule

`default_nettype wire

//--- tb/oring_ctrl_chk.sv
// Purpose: Assertions on gate and load outputs of the OR-ing controller
// Assumes: Pins pass a 3-stage sync and a filter flop, then one decision edge
// Notes:   Bounds leave a little slack over sync plus decision
`default_nettype none
module oring_chk (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic INPUT_RAIL_A_ABOVE_LOW,
  input wire logic INPUT_RAIL_A_ABOVE_HIGH,
  input wire logic INPUT_RAIL_B_ABOVE_LOW,
  input wire logic INPUT_RAIL_B_ABOVE_HIGH,
  input wire logic LIMB_A_CURRENT_SENSE_ABOVE_ON,
  input wire logic LIMB_A_CURRENT_SENSE_BELOW_OFF,
  input wire logic LIMB_B_CURRENT_SENSE_ABOVE_ON,
  input wire logic LIMB_B_CURRENT_SENSE_BELOW_OFF,
  input wire logic LOAD_GOOD,
  input wire logic LOAD_ENABLE,
  input wire logic GATE_A,
  input wire logic GATE_B
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ==========================================
  // Helpers
  wire a_on = LIMB_A_CURRENT_SENSE_ABOVE_ON & !LIMB_A_CURRENT_SENSE_BELOW_OFF;
  wire b_on = LIMB_B_CURRENT_SENSE_ABOVE_ON & !LIMB_B_CURRENT_SENSE_BELOW_OFF;
  // Any rail inside its window
  wire rail_ok = (INPUT_RAIL_A_ABOVE_LOW & !INPUT_RAIL_A_ABOVE_HIGH) |
                 (INPUT_RAIL_B_ABOVE_LOW & !INPUT_RAIL_B_ABOVE_HIGH);
  // Run bit as software last wrote it; set after reset
  logic run_set;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      run_set <= 1'b1;
    end else if (WR && ADDR == 4'h0) begin
      run_set <= WDATA[0];
    end
  end
  sequence s_a_low;
    LIMB_A_CURRENT_SENSE_BELOW_OFF [*7];
  endsequence
  sequence s_b_low;
    LIMB_B_CURRENT_SENSE_BELOW_OFF [*7];
  endsequence
  sequence s_both_high;
    (a_on && b_on && LOAD_GOOD && LOAD_ENABLE) [*8];
  endsequence
  // ==========================================
  // Assertions
  a_reset_gates_off: assert property ($fell(RST) |-> !GATE_A && !GATE_B && !LOAD_ENABLE)
    else $error("outputs not off after reset");
  a_rail_wait: assert property (!rail_ok [*7] |-> !LOAD_ENABLE)
    else $error("load enabled without valid rail");
  a_load_enable: assert property ((rail_ok && run_set) [*8] |-> LOAD_ENABLE)
    else $error("load not enabled");
  a_load_first: assert property ($rose(GATE_A) || $rose(GATE_B) |-> $past(LOAD_GOOD, 3))
    else $error("gate closed before load good");
  a_gate_live: assert property (GATE_A || GATE_B |-> LOAD_ENABLE)
    else $error("gate on while load off");
  a_a_close: assert property ($rose(GATE_A) |-> $past(a_on, 3))
    else $error("gate A closed without current");
  a_b_close: assert property ($rose(GATE_B) |-> $past(b_on, 3))
    else $error("gate B closed without current");
  a_both_share: assert property (s_both_high |-> GATE_A && GATE_B)
    else $error("both gates not on");
  a_a_open: assert property (s_a_low |-> !GATE_A)
    else $error("gate A late off");
  a_b_open: assert property (s_b_low |-> !GATE_B)
    else $error("gate B late off");
endmodule
bind oring_ctrl oring_chk u_chk (
  .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .INPUT_RAIL_A_ABOVE_LOW(INPUT_RAIL_A_ABOVE_LOW),
  .INPUT_RAIL_A_ABOVE_HIGH(INPUT_RAIL_A_ABOVE_HIGH),
  .INPUT_RAIL_B_ABOVE_LOW(INPUT_RAIL_B_ABOVE_LOW),
  .INPUT_RAIL_B_ABOVE_HIGH(INPUT_RAIL_B_ABOVE_HIGH),
  .LIMB_A_CURRENT_SENSE_ABOVE_ON(LIMB_A_CURRENT_SENSE_ABOVE_ON),
  .LIMB_A_CURRENT_SENSE_BELOW_OFF(LIMB_A_CURRENT_SENSE_BELOW_OFF),
  .LIMB_B_CURRENT_SENSE_ABOVE_ON(LIMB_B_CURRENT_SENSE_ABOVE_ON),
  .LIMB_B_CURRENT_SENSE_BELOW_OFF(LIMB_B_CURRENT_SENSE_BELOW_OFF),
  .LOAD_GOOD(LOAD_GOOD), .LOAD_ENABLE(LOAD_ENABLE), .GATE_A(GATE_A), .GATE_B(GATE_B)
);
`default_nettype wire

//--- tb/supply_side.sv
// Purpose: Comparators, rail monitors and load beyond the controller
// Assumes: Currents and rails given as 8-bit codes by the bench
// Notes:   hold keeps the load from reporting on (slow start)
`default_nettype none
module supply_side #(
  parameter int DLY = 5
) (
  input wire logic       CLOCK,
  input wire logic       LOAD_ENABLE,
  input wire logic       hold,
  input wire logic [7:0] cur_a,
  input wire logic [7:0] cur_b,
  input wire logic [7:0] rail_a,
  input wire logic [7:0] rail_b,
  input wire logic [7:0] RAIL_LOW_LEVEL,
  input wire logic [7:0] RAIL_HIGH_LEVEL,
  input wire logic [7:0] LIMB_A_ON_LEVEL,
  input wire logic [7:0] LIMB_A_OFF_LEVEL,
  input wire logic [7:0] LIMB_B_ON_LEVEL,
  input wire logic [7:0] LIMB_B_OFF_LEVEL,
  output logic           INPUT_RAIL_A_ABOVE_LOW,
  output logic           INPUT_RAIL_A_ABOVE_HIGH,
  output logic           INPUT_RAIL_B_ABOVE_LOW,
  output logic           INPUT_RAIL_B_ABOVE_HIGH,
  output logic           LIMB_A_CURRENT_SENSE_ABOVE_ON,
  output logic           LIMB_A_CURRENT_SENSE_BELOW_OFF,
  output logic           LIMB_B_CURRENT_SENSE_ABOVE_ON,
  output logic           LIMB_B_CURRENT_SENSE_BELOW_OFF,
  output logic           LOAD_GOOD
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;  // Cycles since load enabled
  // ==========================================
  // Window comparators on the set levels
  assign INPUT_RAIL_A_ABOVE_LOW = rail_a > RAIL_LOW_LEVEL;
  assign INPUT_RAIL_A_ABOVE_HIGH = rail_a > RAIL_HIGH_LEVEL;
  assign INPUT_RAIL_B_ABOVE_LOW = rail_b > RAIL_LOW_LEVEL;
  assign INPUT_RAIL_B_ABOVE_HIGH = rail_b > RAIL_HIGH_LEVEL;
  // Two comparators per limb, separate levels
  assign LIMB_A_CURRENT_SENSE_ABOVE_ON = cur_a > LIMB_A_ON_LEVEL;
  assign LIMB_A_CURRENT_SENSE_BELOW_OFF = cur_a < LIMB_A_OFF_LEVEL;
  assign LIMB_B_CURRENT_SENSE_ABOVE_ON = cur_b > LIMB_B_ON_LEVEL;
  assign LIMB_B_CURRENT_SENSE_BELOW_OFF = cur_b < LIMB_B_OFF_LEVEL;
  // ==========================================
  // Load starts some cycles after enable
  always_ff @(posedge CLOCK) begin
    if (!LOAD_ENABLE || hold) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end
  assign LOAD_GOOD = cnt >= DLY;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the OR-ing controller
// Assumes: Control register at its reset value (run, both limbs) except inside t_level, which writes it and restores 07
// Notes:   Waits of 10 cycles cover the 3-stage pin sync
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CLOCK, RST, WR, RD, hold;
  logic [3:0] ADDR;
  logic [7:0] WDATA, cur_a, cur_b, rail_a, rail_b, rv;
  wire  [7:0] RDATA, RAIL_LOW_LEVEL, RAIL_HIGH_LEVEL, LIMB_A_ON_LEVEL;
  wire  [7:0] LIMB_A_OFF_LEVEL, LIMB_B_ON_LEVEL, LIMB_B_OFF_LEVEL;
  wire        LOAD_GOOD, LOAD_ENABLE, GATE_A, GATE_B;
  wire        INPUT_RAIL_A_ABOVE_LOW, INPUT_RAIL_A_ABOVE_HIGH;
  wire        INPUT_RAIL_B_ABOVE_LOW, INPUT_RAIL_B_ABOVE_HIGH;
  wire        LIMB_A_CURRENT_SENSE_ABOVE_ON, LIMB_A_CURRENT_SENSE_BELOW_OFF;
  wire        LIMB_B_CURRENT_SENSE_ABOVE_ON, LIMB_B_CURRENT_SENSE_BELOW_OFF;
  int         failures, tests_run;
  logic [7:0] rst_val [8] = '{8'h07, 8'h00, 8'hA0, 8'hC0, 8'h40, 8'h20, 8'h40, 8'h20};
  oring_ctrl u_dut (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA),
    .INPUT_RAIL_A_ABOVE_LOW(INPUT_RAIL_A_ABOVE_LOW),
    .INPUT_RAIL_A_ABOVE_HIGH(INPUT_RAIL_A_ABOVE_HIGH),
    .INPUT_RAIL_B_ABOVE_LOW(INPUT_RAIL_B_ABOVE_LOW),
    .INPUT_RAIL_B_ABOVE_HIGH(INPUT_RAIL_B_ABOVE_HIGH),
    .LIMB_A_CURRENT_SENSE_ABOVE_ON(LIMB_A_CURRENT_SENSE_ABOVE_ON),
    .LIMB_A_CURRENT_SENSE_BELOW_OFF(LIMB_A_CURRENT_SENSE_BELOW_OFF),
    .LIMB_B_CURRENT_SENSE_ABOVE_ON(LIMB_B_CURRENT_SENSE_ABOVE_ON),
    .LIMB_B_CURRENT_SENSE_BELOW_OFF(LIMB_B_CURRENT_SENSE_BELOW_OFF),
    .LOAD_GOOD(LOAD_GOOD), .LOAD_ENABLE(LOAD_ENABLE), .GATE_A(GATE_A), .GATE_B(GATE_B),
    .RAIL_LOW_LEVEL(RAIL_LOW_LEVEL), .RAIL_HIGH_LEVEL(RAIL_HIGH_LEVEL),
    .LIMB_A_ON_LEVEL(LIMB_A_ON_LEVEL), .LIMB_A_OFF_LEVEL(LIMB_A_OFF_LEVEL),
    .LIMB_B_ON_LEVEL(LIMB_B_ON_LEVEL), .LIMB_B_OFF_LEVEL(LIMB_B_OFF_LEVEL)
  );
  supply_side u_side (
    .CLOCK(CLOCK), .LOAD_ENABLE(LOAD_ENABLE), .hold(hold), .cur_a(cur_a),
    .cur_b(cur_b), .rail_a(rail_a), .rail_b(rail_b),
    .RAIL_LOW_LEVEL(RAIL_LOW_LEVEL), .RAIL_HIGH_LEVEL(RAIL_HIGH_LEVEL),
    .LIMB_A_ON_LEVEL(LIMB_A_ON_LEVEL), .LIMB_A_OFF_LEVEL(LIMB_A_OFF_LEVEL),
    .LIMB_B_ON_LEVEL(LIMB_B_ON_LEVEL), .LIMB_B_OFF_LEVEL(LIMB_B_OFF_LEVEL),
    .INPUT_RAIL_A_ABOVE_LOW(INPUT_RAIL_A_ABOVE_LOW),
    .INPUT_RAIL_A_ABOVE_HIGH(INPUT_RAIL_A_ABOVE_HIGH),
    .INPUT_RAIL_B_ABOVE_LOW(INPUT_RAIL_B_ABOVE_LOW),
    .INPUT_RAIL_B_ABOVE_HIGH(INPUT_RAIL_B_ABOVE_HIGH),
    .LIMB_A_CURRENT_SENSE_ABOVE_ON(LIMB_A_CURRENT_SENSE_ABOVE_ON),
    .LIMB_A_CURRENT_SENSE_BELOW_OFF(LIMB_A_CURRENT_SENSE_BELOW_OFF),
    .LIMB_B_CURRENT_SENSE_ABOVE_ON(LIMB_B_CURRENT_SENSE_ABOVE_ON),
    .LIMB_B_CURRENT_SENSE_BELOW_OFF(LIMB_B_CURRENT_SENSE_BELOW_OFF),
    .LOAD_GOOD(LOAD_GOOD)
  );
  // ==========================================
  // Clock, 25 ns
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  task automatic set(input logic [7:0] a, input logic [7:0] b);
    @(posedge CLOCK);
    cur_a <= a;
    cur_b <= b;
    tick(10);
  endtask
  task automatic gates(input logic ga, input logic gb);
    check({7'h00, GATE_A}, {7'h00, ga});
    check({7'h00, GATE_B}, {7'h00, gb});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    gates(1'b0, 1'b0);
    check({7'h00, LOAD_ENABLE}, 8'h00);
    check(RAIL_LOW_LEVEL, 8'hA0);
    check(LIMB_A_ON_LEVEL, 8'h40);
    check(LIMB_A_OFF_LEVEL, 8'h20);
    check(LIMB_B_ON_LEVEL, 8'h40);
    check(LIMB_B_OFF_LEVEL, 8'h20);
    for (int i = 0; i < 8; i++) begin
      rd(i[3:0]);
      check(rv, rst_val[i]);
    end
    wr(4'h1, 8'hFF);
    rd(4'h1);
    check(rv, 8'h00);
    rd(4'h9);
    check(rv, 8'h00);
    wr(4'h3, 8'hB8);
    tick(1);
    check(RAIL_HIGH_LEVEL, 8'hB8);
    wr(4'h3, 8'hC0);
  endtask
  // Overvoltage on A, B under window
  task automatic t_norail;
    rail_a <= 8'hC8;
    rail_b <= 8'h50;
    set(8'h60, 8'h60);
    tick(10);
    check({7'h00, LOAD_ENABLE}, 8'h00);
    gates(1'b0, 1'b0);
  endtask
  task automatic t_start;
    rail_a <= 8'hB0;
    set(8'h60, 8'h10);
    check({7'h00, LOAD_ENABLE}, 8'h01);
    tick(10);
    gates(1'b0, 1'b0);
    rd(4'h1);
    check(rv, 8'h32);
    hold <= 1'b0;
    tick(15);
    gates(1'b1, 1'b0);
    set(8'h60, 8'h60);
    gates(1'b1, 1'b1);
    rd(4'h1);
    check(rv, 8'hBF);
  endtask
  // Hysteresis band 20..40, repeated
  task automatic t_hyst;
    for (int i = 0; i < 2; i++) begin
      set(8'h30, 8'h60);
      gates(1'b1, 1'b1);
      set(8'h10, 8'h60);
      gates(1'b0, 1'b1);
      set(8'h30, 8'h30);
      gates(1'b0, 1'b1);
      set(8'h60, 8'h10);
      gates(1'b1, 1'b0);
    end
  endtask
  // New turn-on level takes effect
  task automatic t_level;
    wr(4'h4, 8'h80);
    set(8'h10, 8'h10);
    set(8'h60, 8'h10);
    gates(1'b0, 1'b0);
    wr(4'h4, 8'h50);
    tick(10);
    gates(1'b1, 1'b0);
    // Limb A forbidden by software; upper bits masked
    wr(4'h0, 8'hFD);
    tick(10);
    gates(1'b0, 1'b0);
    rd(4'h0);
    check(rv, 8'h05);
    // Run cleared: back to the wait state, then restart
    wr(4'h0, 8'h06);
    tick(10);
    check({7'h00, LOAD_ENABLE}, 8'h00);
    gates(1'b0, 1'b0);
    wr(4'h0, 8'h07);
    tick(20);
    check({7'h00, LOAD_ENABLE}, 8'h01);
    gates(1'b1, 1'b0);
  endtask
  task automatic t_loss;
    rail_a <= 8'h50;
    tick(10);
    check({7'h00, LOAD_ENABLE}, 8'h00);
    gates(1'b0, 1'b0);
  endtask
  // ==========================================
  // Verdict
  task automatic wrap_up;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, runs total well under 2000 cycles
  initial begin
    tick(5000);
    failures++;
    wrap_up();
  end
  initial begin
    {RST, hold, WR, RD} = 4'hC;
    {ADDR, WDATA, cur_a, cur_b, rail_a, rail_b} = '0;
    failures = 0;
    tests_run = 0;
    tick(8);
    RST <= 1'b0;
    t_regs();
    t_norail();
    t_start();
    t_hyst();
    t_level();
    t_loss();
    wrap_up();
  end
endmodule
`default_nettype wire
